//--- src/sdc_pkg.sv
// constants for the segment descriptor checker
// assumes 16-bit descriptor words, descriptor access byte in word 2 high byte
package sdc_pkg;
  // register byte offsets
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_DADDR = 8'h04;
  localparam logic [7:0] ADDR_GADDR = 8'h08;
  localparam logic [7:0] ADDR_OFFS = 8'h0C;
  localparam logic [7:0] ADDR_STAT = 8'h10;
  localparam logic [7:0] ADDR_GATE = 8'h14;
  localparam logic [7:0] ADDR_SBASE = 8'h18;
  localparam logic [7:0] ADDR_SLIM = 8'h1C;
  // access byte fields
  localparam int AB_P = 7;
  localparam int AB_PRIV_LO = 5;
  localparam int AB_S = 4;
  localparam int AB_E = 3;
  localparam int AB_EC = 2;
  localparam int AB_WR = 1;
  localparam int AB_A = 0;
  // system and gate type codes
  localparam logic [2:0] TY_TSS_AVL = 3'h1;
  localparam logic [2:0] TY_LDT = 3'h2;
  localparam logic [2:0] TY_TSS_BUSY = 3'h3;
  localparam logic [2:0] TY_CALL = 3'h4;
  localparam logic [2:0] TY_TASK = 3'h5;
  localparam logic [2:0] TY_INT = 3'h6;
  localparam logic [2:0] TY_TRAP = 3'h7;
  // exception vectors
  localparam logic [7:0] EXC_NP = 8'h0B;
  localparam logic [7:0] EXC_GP = 8'h0D;
  // commands and access kinds
  localparam logic [2:0] CMD_LOAD = 3'h1;
  localparam logic [2:0] CMD_GATE = 3'h2;
  localparam logic [2:0] CMD_SYS = 3'h3;
  localparam logic [2:0] CMD_CHECK = 3'h4;
  localparam logic [1:0] ACC_RD = 2'h0;
  localparam logic [1:0] ACC_WR = 2'h1;
  localparam logic [1:0] ACC_EX = 2'h2;
  // segment register slots
  localparam logic [1:0] SEG_CODE = 2'h0;
  localparam logic [1:0] SEG_STACK = 2'h1;
  // ctrl fields, access byte word index, status reset value and engine states
  localparam int CT_SEG = 4;
  localparam int CT_KIND = 8;
  localparam int CT_IESET = 12;
  localparam logic [1:0] WORD_ACC = 2'h2;
  localparam logic [31:0] STAT_RST = 32'h0000_0000;
  typedef enum logic [2:0] {ST_IDLE, ST_RD, ST_EVAL, ST_WR, ST_CHK} sdc_state_t;
endpackage

//--- src/sdc_decode.sv
// access byte classifier
// assumes a descriptor access byte on its input, purely combinational
`timescale 1ns/10ps
`default_nettype none
module sdc_decode (
  input wire logic [7:0] acc,
  output logic present,
  output logic [1:0] priv,
  output logic is_code,
  output logic is_data,
  output logic is_sys,
  output logic is_gate,
  output logic [2:0] typ,
  output logic flag_ec,
  output logic flag_wr
);
  always_comb begin
    present = acc[sdc_pkg::AB_P];
    priv = acc[sdc_pkg::AB_PRIV_LO +: 2];
    is_code = acc[sdc_pkg::AB_S] && acc[sdc_pkg::AB_E];
    is_data = acc[sdc_pkg::AB_S] && !acc[sdc_pkg::AB_E];
    is_sys = !acc[sdc_pkg::AB_S] && acc[3:2] == 2'h0 && acc[1:0] != 2'h0;
    is_gate = !acc[sdc_pkg::AB_S] && acc[3:2] == 2'h1;
    typ = acc[2:0];
    flag_ec = acc[sdc_pkg::AB_EC];
    flag_wr = acc[sdc_pkg::AB_WR];
  end
endmodule
`default_nettype wire

//--- src/sdc_cache.sv
// hidden descriptor cache, one entry per segment register
// assumes one write port and a registered read port
`timescale 1ns/10ps
`default_nettype none
module sdc_cache #(
  parameter int W = 48,
  parameter int D = 4
) (
  input wire logic hclk,
  input wire logic we,
  input wire logic [$clog2(D)-1:0] waddr,
  input wire logic [W-1:0] wdata,
  input wire logic [$clog2(D)-1:0] raddr,
  output logic [W-1:0] rdata
);
  logic [W-1:0] mem [D];
  always_ff @(posedge hclk) begin
    if (we) begin
      mem[waddr] <= wdata;
    end
    rdata <= mem[raddr];
  end
endmodule
`default_nettype wire

//--- src/sdc_checker.sv
// segment descriptor checker with AHB-Lite register port
// assumes one slave on the bus and a locked word port to descriptor memory
//
// Behaviour
// - executable set with class set means code; executable clear with class set means data
// - code or data load with present clear raises not-present; a gate destination's present bit is not checked
// - accessed bit written back to memory on every code or data load that passes its checks
// - writes to a data segment with writable clear are refused
// - expand direction selects grow-up or grow-down limit meaning
// - code never written; execute-only code never read
// - conforming code reports its privilege as lowest allowed level
// - system types: 1 free task state, 2 local table, 3 busy task
// - system descriptor yields 24-bit base and 16-bit last-byte limit
// - class bit 4 clear marks a system or gate descriptor
// - local table descriptor privilege ignored; only task state uses it
// - system descriptor valid only when present
// - gate types 4..7: call, task, interrupt, trap
// - interrupt gate clears interrupt enable; trap gate leaves it
// - wrong destination type for a gate raises exception 13
// - task gate destination offset is ignored
// - word count reported only for call gates
// - non-present gate raises exception 11
// - one cache per segment register, reloaded on each load that passes its checks
// - only code or data descriptors enter the cache
// - checks use the cache, never fetch memory again
// - no software read path to the caches
// - access byte bit layout from present down to accessed
// - grow-up needs offset at most limit; grow-down above limit
// - every descriptor fetch and update is one locked sequence
//
// The AHB-Lite interface to the registers and the address map were decided locally.
`timescale 1ns/10ps
`default_nettype none
module sdc_checker (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  output logic mem_req,
  output logic mem_we,
  output logic mem_lock,
  output logic [23:0] mem_addr,
  output logic [15:0] mem_wdata,
  input wire logic [15:0] mem_rdata,
  input wire logic mem_ack,
  output logic int_enable
);
  // bus group
  logic wr_pend_r, wr_pend_nxt, rd_pend_r, rd_pend_nxt, rd_done_r, rd_done_nxt;
  logic [7:0] adr_r, adr_nxt;
  logic [31:0] hrdata_r, hrdata_nxt, rmux;
  logic ap;
  // engine group
  sdc_pkg::sdc_state_t st_r, st_nxt;
  logic [2:0] cmd_r, cmd_nxt, gtyp_r, gtyp_nxt, typ_r, typ_nxt;
  logic [1:0] seg_r, seg_nxt, kind_r, kind_nxt, idx_r, idx_nxt, priv_r, priv_nxt;
  logic ph_r, ph_nxt, done_r, done_nxt, fault_r, fault_nxt, ie_r, ie_nxt;
  logic conf_r, conf_nxt;
  logic [7:0] exc_r, exc_nxt;
  logic [15:0] w0_r, w0_nxt, w1_r, w1_nxt, w2_r, w2_nxt, offs_r, offs_nxt;
  logic [15:0] dsel_r, dsel_nxt, doff_r, doff_nxt, slim_r, slim_nxt;
  logic [23:0] daddr_r, daddr_nxt, gaddr_r, gaddr_nxt, sbase_r, sbase_nxt;
  logic [4:0] cnt_r, cnt_nxt;
  logic [3:0] valid_r, valid_nxt;
  logic req_r, req_nxt, we_r, we_nxt, lock_r, lock_nxt;
  logic [23:0] maddr_r, maddr_nxt;
  logic [15:0] mwd_r, mwd_nxt;
  logic cwe;
  logic [47:0] crd;
  // decoded fields of the fetched and the cached descriptor
  logic d_p, d_code, d_data, d_sys, d_gate, d_ec, d_wr;
  logic c_p, c_code, c_data, c_sys, c_gate, c_ec, c_wr;
  logic [1:0] d_priv, c_priv;
  logic [2:0] d_typ, c_typ;

  sdc_decode u_dec_fetch (
    .acc(w2_r[15:8]), .present(d_p), .priv(d_priv), .is_code(d_code), .is_data(d_data),
    .is_sys(d_sys), .is_gate(d_gate), .typ(d_typ), .flag_ec(d_ec), .flag_wr(d_wr)
  );
  sdc_decode u_dec_cache (
    .acc(crd[47:40]), .present(c_p), .priv(c_priv), .is_code(c_code), .is_data(c_data),
    .is_sys(c_sys), .is_gate(c_gate), .typ(c_typ), .flag_ec(c_ec), .flag_wr(c_wr)
  );
  // cache fills only from the write-back cycle; no read path to registers
  sdc_cache #(.W(48), .D(4)) u_cache (
    .hclk(hclk), .we(cwe), .waddr(seg_r), .wdata({w2_r, w1_r, w0_r}),
    .raddr(seg_r), .rdata(crd)
  );

  assign ap = hsel && hready && htrans[1];
  assign hreadyout = !(rd_pend_r && !rd_done_r);
  assign hresp = 1'b0;
  assign hrdata = hrdata_r;
  assign mem_req = req_r;
  assign mem_we = we_r;
  assign mem_lock = lock_r;
  assign mem_addr = maddr_r;
  assign mem_wdata = mwd_r;
  assign int_enable = ie_r;
  assign cwe = st_r == sdc_pkg::ST_WR && mem_ack;

  always_comb begin
    case (adr_r)
      sdc_pkg::ADDR_CTRL: rmux = {19'h0, ie_r, 2'h0, kind_r, 2'h0, seg_r, 1'b0, cmd_r};
      sdc_pkg::ADDR_DADDR: rmux = {8'h0, daddr_r};
      sdc_pkg::ADDR_GADDR: rmux = {8'h0, gaddr_r};
      sdc_pkg::ADDR_OFFS: rmux = {16'h0, offs_r};
      sdc_pkg::ADDR_STAT: rmux = {3'h0, cnt_r, priv_r, conf_r, ie_r, 1'b0, typ_r, exc_r, 5'h0,
                                  fault_r, done_r, st_r != sdc_pkg::ST_IDLE};
      sdc_pkg::ADDR_GATE: rmux = {dsel_r, doff_r};
      sdc_pkg::ADDR_SBASE: rmux = {8'h0, sbase_r};
      sdc_pkg::ADDR_SLIM: rmux = {16'h0, slim_r};
      default: rmux = 32'h0000_0000;
    endcase
  end

  always_comb begin
    wr_pend_nxt = wr_pend_r;
    rd_pend_nxt = rd_pend_r;
    adr_nxt = adr_r;
    if (hready) begin
      wr_pend_nxt = ap && hwrite;
      rd_pend_nxt = ap && !hwrite;
      adr_nxt = ap ? haddr[7:0] : adr_r;
    end
    // reads take one wait state so read data leave a flip-flop
    rd_done_nxt = rd_pend_r && !rd_done_r;
    hrdata_nxt = (rd_pend_r && !rd_done_r) ? rmux : hrdata_r;
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend_r <= 1'b0;
      rd_pend_r <= 1'b0;
      rd_done_r <= 1'b0;
      adr_r <= 8'h00;
      hrdata_r <= 32'h0000_0000;
    end else begin
      wr_pend_r <= wr_pend_nxt;
      rd_pend_r <= rd_pend_nxt;
      rd_done_r <= rd_done_nxt;
      adr_r <= adr_nxt;
      hrdata_r <= hrdata_nxt;
    end
  end

  always_comb begin
    st_nxt = st_r; cmd_nxt = cmd_r; seg_nxt = seg_r; kind_nxt = kind_r; idx_nxt = idx_r;
    ph_nxt = ph_r; done_nxt = done_r; fault_nxt = fault_r; exc_nxt = exc_r; ie_nxt = ie_r;
    conf_nxt = conf_r; priv_nxt = priv_r; typ_nxt = typ_r; gtyp_nxt = gtyp_r; cnt_nxt = cnt_r;
    w0_nxt = w0_r; w1_nxt = w1_r; w2_nxt = w2_r; offs_nxt = offs_r; dsel_nxt = dsel_r;
    doff_nxt = doff_r; slim_nxt = slim_r; daddr_nxt = daddr_r; gaddr_nxt = gaddr_r;
    sbase_nxt = sbase_r; valid_nxt = valid_r; req_nxt = req_r; we_nxt = we_r;
    lock_nxt = lock_r; maddr_nxt = maddr_r; mwd_nxt = mwd_r;
    // register writes are taken only while idle
    if (wr_pend_r && st_r == sdc_pkg::ST_IDLE) begin
      case (adr_r)
        sdc_pkg::ADDR_DADDR: daddr_nxt = hwdata[23:0];
        sdc_pkg::ADDR_GADDR: gaddr_nxt = hwdata[23:0];
        sdc_pkg::ADDR_OFFS: offs_nxt = hwdata[15:0];
        sdc_pkg::ADDR_CTRL: begin
          if (hwdata[sdc_pkg::CT_IESET]) begin
            ie_nxt = 1'b1;
          end
          cmd_nxt = hwdata[2:0];
          seg_nxt = hwdata[sdc_pkg::CT_SEG +: 2];
          kind_nxt = hwdata[sdc_pkg::CT_KIND +: 2];
          idx_nxt = 2'h0;
          ph_nxt = 1'b0;
          done_nxt = 1'b0;
          fault_nxt = 1'b0;
          exc_nxt = 8'h00;
          if (hwdata[2:0] == sdc_pkg::CMD_CHECK) begin
            st_nxt = sdc_pkg::ST_CHK;
          end else if (hwdata[2:0] != 3'h0 && hwdata[2:0] < sdc_pkg::CMD_CHECK) begin
            st_nxt = sdc_pkg::ST_RD;
            req_nxt = 1'b1;
            we_nxt = 1'b0;
            lock_nxt = 1'b1;
            maddr_nxt = daddr_r;
          end
        end
        default: ;
      endcase
    end
    case (st_r)
      sdc_pkg::ST_IDLE: ;
      sdc_pkg::ST_RD: begin
        if (mem_ack) begin
          case (idx_r)
            2'h0: w0_nxt = mem_rdata;
            2'h1: w1_nxt = mem_rdata;
            default: w2_nxt = mem_rdata;
          endcase
          if (idx_r == sdc_pkg::WORD_ACC) begin
            req_nxt = 1'b0;
            st_nxt = sdc_pkg::ST_EVAL;
          end else begin
            idx_nxt = idx_r + 2'h1;
            maddr_nxt = maddr_r + 24'h00_0002;
          end
        end
      end
      sdc_pkg::ST_CHK: st_nxt = sdc_pkg::ST_EVAL;
      sdc_pkg::ST_WR: begin
        if (mem_ack) begin
          req_nxt = 1'b0;
          we_nxt = 1'b0;
          lock_nxt = 1'b0;
          valid_nxt[seg_r] = 1'b1;
          done_nxt = 1'b1;
          st_nxt = sdc_pkg::ST_IDLE;
        end
      end
      sdc_pkg::ST_EVAL: begin
        done_nxt = 1'b1;
        lock_nxt = 1'b0;
        st_nxt = sdc_pkg::ST_IDLE;
        exc_nxt = sdc_pkg::EXC_GP;
        fault_nxt = 1'b1;
        typ_nxt = d_typ;
        priv_nxt = d_priv;
        case (cmd_r)
          sdc_pkg::CMD_LOAD: begin
            if (!d_code && !d_data) begin
              fault_nxt = 1'b1;
            end else if (!d_p) begin
              exc_nxt = sdc_pkg::EXC_NP;
            end else if ((seg_r == sdc_pkg::SEG_CODE && !d_code) ||
                         (seg_r == sdc_pkg::SEG_STACK && !(d_data && d_wr)) ||
                         (seg_r > sdc_pkg::SEG_STACK && d_code && !d_wr)) begin
              fault_nxt = 1'b1;
            end else begin
              // write back the access byte with accessed set, still locked
              fault_nxt = 1'b0;
              exc_nxt = 8'h00;
              done_nxt = 1'b0;
              lock_nxt = 1'b1;
              req_nxt = 1'b1;
              we_nxt = 1'b1;
              maddr_nxt = daddr_r + 24'h00_0004;
              w2_nxt = w2_r | (16'h0100 << sdc_pkg::AB_A);
              mwd_nxt = w2_r | (16'h0100 << sdc_pkg::AB_A);
              valid_nxt[seg_r] = 1'b0;
              conf_nxt = d_code && d_ec;
              st_nxt = sdc_pkg::ST_WR;
            end
          end
          sdc_pkg::CMD_GATE: begin
            if (!ph_r) begin
              if (!d_gate) begin
                fault_nxt = 1'b1;
              end else if (!d_p) begin
                exc_nxt = sdc_pkg::EXC_NP;
              end else begin
                fault_nxt = 1'b0;
                exc_nxt = 8'h00;
                done_nxt = 1'b0;
                gtyp_nxt = d_typ;
                dsel_nxt = w1_r;
                doff_nxt = (d_typ == sdc_pkg::TY_TASK) ? 16'h0000 : w0_r;
                cnt_nxt = (d_typ == sdc_pkg::TY_CALL) ? w2_r[4:0] : 5'h00;
                ph_nxt = 1'b1;
                idx_nxt = 2'h0;
                req_nxt = 1'b1;
                lock_nxt = 1'b1;
                maddr_nxt = gaddr_r;
                st_nxt = sdc_pkg::ST_RD;
              end
            end else begin
              typ_nxt = gtyp_r;
              if (gtyp_r == sdc_pkg::TY_TASK ? !(d_sys && d_typ != sdc_pkg::TY_LDT) : !d_code) begin
                fault_nxt = 1'b1;
              end else begin
                fault_nxt = 1'b0;
                exc_nxt = 8'h00;
                if (gtyp_r == sdc_pkg::TY_INT) begin
                  ie_nxt = 1'b0;
                end
              end
            end
          end
          sdc_pkg::CMD_SYS: begin
            if (!d_sys) begin
              fault_nxt = 1'b1;
            end else if (!d_p) begin
              exc_nxt = sdc_pkg::EXC_NP;
            end else begin
              fault_nxt = 1'b0;
              exc_nxt = 8'h00;
              sbase_nxt = {w2_r[7:0], w1_r};
              slim_nxt = w0_r;
              priv_nxt = (d_typ == sdc_pkg::TY_LDT) ? 2'h0 : d_priv;
            end
          end
          sdc_pkg::CMD_CHECK: begin
            typ_nxt = c_typ;
            priv_nxt = c_priv;
            conf_nxt = c_code && c_ec;
            if (!valid_r[seg_r]) begin
              fault_nxt = 1'b1;
            end else if (kind_r == sdc_pkg::ACC_WR && (c_code || !c_wr)) begin
              fault_nxt = 1'b1;
            end else if (kind_r == sdc_pkg::ACC_RD && c_code && !c_wr) begin
              fault_nxt = 1'b1;
            end else if (kind_r == sdc_pkg::ACC_EX && !c_code) begin
              fault_nxt = 1'b1;
            end else if ((c_data && c_ec) ? offs_r <= crd[15:0] : offs_r > crd[15:0]) begin
              fault_nxt = 1'b1;
            end else begin
              fault_nxt = 1'b0;
              exc_nxt = 8'h00;
            end
          end
          default: ;
        endcase
      end
      default: st_nxt = sdc_pkg::ST_IDLE;
    endcase
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      st_r <= sdc_pkg::ST_IDLE;
      {cmd_r, gtyp_r, typ_r, seg_r, kind_r, idx_r, priv_r} <= 17'h0_0000;
      {ph_r, done_r, fault_r, ie_r, conf_r} <= 5'h00;
      exc_r <= 8'h00;
      {w0_r, w1_r, w2_r, offs_r, dsel_r, doff_r, slim_r} <= 112'h0;
      {daddr_r, gaddr_r, sbase_r} <= 72'h0;
      cnt_r <= 5'h00;
      valid_r <= 4'h0;
      {req_r, we_r, lock_r} <= 3'h0;
      maddr_r <= 24'h00_0000;
      mwd_r <= 16'h0000;
    end else begin
      st_r <= st_nxt;
      {cmd_r, gtyp_r, typ_r, seg_r, kind_r, idx_r, priv_r} <=
        {cmd_nxt, gtyp_nxt, typ_nxt, seg_nxt, kind_nxt, idx_nxt, priv_nxt};
      {ph_r, done_r, fault_r, ie_r, conf_r} <= {ph_nxt, done_nxt, fault_nxt, ie_nxt, conf_nxt};
      exc_r <= exc_nxt;
      {w0_r, w1_r, w2_r, offs_r, dsel_r, doff_r, slim_r} <=
        {w0_nxt, w1_nxt, w2_nxt, offs_nxt, dsel_nxt, doff_nxt, slim_nxt};
      {daddr_r, gaddr_r, sbase_r} <= {daddr_nxt, gaddr_nxt, sbase_nxt};
      cnt_r <= cnt_nxt;
      valid_r <= valid_nxt;
      {req_r, we_r, lock_r} <= {req_nxt, we_nxt, lock_nxt};
      maddr_r <= maddr_nxt;
      mwd_r <= mwd_nxt;
    end
  end

  AST_LOCKED: assert property (@(posedge hclk) disable iff (!hresetn)
    mem_req |-> mem_lock) else $error("descriptor access not locked");
  AST_ACC_BIT: assert property (@(posedge hclk) disable iff (!hresetn)
    (mem_req && mem_we) |-> mem_wdata[8] && mem_addr == daddr_r + 24'h00_0004)
    else $error("write-back lacks accessed bit");
  AST_CACHE_CD: assert property (@(posedge hclk) disable iff (!hresetn)
    cwe |-> w2_r[12]) else $error("system descriptor cached");
  AST_CHK_NOBUS: assert property (@(posedge hclk) disable iff (!hresetn)
    (st_r == sdc_pkg::ST_CHK) |-> !mem_req ##1 !mem_req) else $error("check used the bus");
  AST_NP_LOAD: assert property (@(posedge hclk) disable iff (!hresetn)
    (st_r == sdc_pkg::ST_EVAL && cmd_r == sdc_pkg::CMD_LOAD && w2_r[12] && !w2_r[15])
    |=> done_r && fault_r && exc_r == sdc_pkg::EXC_NP && !mem_req)
    else $error("not-present load missed");
  AST_NP_GATE: assert property (@(posedge hclk) disable iff (!hresetn)
    (st_r == sdc_pkg::ST_EVAL && cmd_r == sdc_pkg::CMD_GATE && !ph_r && d_gate && !d_p)
    |=> exc_r == sdc_pkg::EXC_NP && st_r == sdc_pkg::ST_IDLE) else $error("gate 11 missed");
  AST_RO_WRITE: assert property (@(posedge hclk) disable iff (!hresetn)
    (st_r == sdc_pkg::ST_EVAL && cmd_r == sdc_pkg::CMD_CHECK && valid_r[seg_r] && c_data &&
     !c_wr && kind_r == sdc_pkg::ACC_WR) |=> fault_r && exc_r == sdc_pkg::EXC_GP)
    else $error("read-only write allowed");
  AST_IE_INT: assert property (@(posedge hclk) disable iff (!hresetn)
    (st_r == sdc_pkg::ST_EVAL && cmd_r == sdc_pkg::CMD_GATE && ph_r && !fault_nxt)
    |=> int_enable == ((gtyp_r != sdc_pkg::TY_INT) && $past(ie_r))) else $error("IE wrong");
  AST_RD_WAIT: assert property (@(posedge hclk) disable iff (!hresetn)
    (rd_pend_r && !rd_done_r) |-> !hreadyout ##1 hreadyout) else $error("read wait wrong");
endmodule
`default_nettype wire

//--- dv/sdc_mem_model.sv
// behavioural descriptor memory on the checker's locked word port
// assumes requests held until acknowledged; slow sets the extra wait cycles
`timescale 1ns/10ps
`default_nettype none
module sdc_mem_model (
  input wire logic hclk,
  input wire logic mem_req,
  input wire logic mem_we,
  input wire logic [23:0] mem_addr,
  input wire logic [15:0] mem_wdata,
  input wire logic [1:0] slow,
  output logic [15:0] mem_rdata,
  output logic mem_ack
);
  logic [15:0] m [0:255];
  logic [1:0] wait_cnt;
  initial begin
    mem_ack = 1'b0;
    mem_rdata = 16'h0000;
    wait_cnt = 2'h0;
  end
  always @(posedge hclk) begin
    if (mem_req && mem_ack && mem_we) begin
      m[mem_addr[8:1]] <= mem_wdata;
    end
    if (mem_req && !mem_ack && wait_cnt == slow) begin
      mem_ack <= 1'b1;
      mem_rdata <= m[mem_addr[8:1]];
      wait_cnt <= 2'h0;
    end else begin
      // data line not held once the word is taken
      mem_ack <= 1'b0;
      mem_rdata <= ~mem_rdata;
      wait_cnt <= (mem_req && !mem_ack) ? wait_cnt + 2'h1 : 2'h0;
    end
  end
endmodule
`default_nettype wire

//--- dv/tb.sv
// register-level testbench of the segment descriptor checker
// assumes one AHB-Lite slave and the behavioural descriptor memory
`timescale 1ns/10ps
`default_nettype none
`define CHK(got, exp, msg) begin n_tests++; if ((got) !== (exp)) begin err_total++; \
  $display("CHECK FAILED %0t %s", $time, msg); end end
module tb;
  logic hclk, hresetn, hsel, hwrite, hreadyout, hresp, mem_req, mem_we, mem_lock, mem_ack, int_enable;
  logic [31:0] haddr, hwdata, hrdata, rd;
  logic [1:0] htrans, slow;
  logic [2:0] hsize, ty;
  logic [23:0] mem_addr;
  logic [15:0] mem_wdata, mem_rdata;
  logic [7:0] ex;
  int err_total, n_tests, cyc, n_mem, n0;
  // seg, access, load exc, kind, offset, check fault; limit 0x0100
  localparam logic [36:0] LT [0:15] = '{
    {2'h0, 8'h9A, 8'h00, 2'h1, 16'h0000, 1'b1}, {2'h0, 8'h9E, 8'h00, 2'h2, 16'h0100, 1'b0},
    {2'h0, 8'h98, 8'h00, 2'h0, 16'h0000, 1'b1}, {2'h0, 8'h92, 8'h0D, 2'h0, 16'h0000, 1'b0},
    {2'h2, 8'hF2, 8'h00, 2'h1, 16'h0100, 1'b0}, {2'h2, 8'h92, 8'h00, 2'h1, 16'h0101, 1'b1},
    {2'h3, 8'h90, 8'h00, 2'h1, 16'h0000, 1'b1}, {2'h3, 8'h90, 8'h00, 2'h0, 16'h0000, 1'b0},
    {2'h1, 8'h96, 8'h00, 2'h1, 16'h0100, 1'b1}, {2'h1, 8'h96, 8'h00, 2'h1, 16'h0101, 1'b0},
    {2'h1, 8'h90, 8'h0D, 2'h0, 16'h0000, 1'b0}, {2'h2, 8'h98, 8'h0D, 2'h0, 16'h0000, 1'b0},
    {2'h2, 8'h12, 8'h0B, 2'h0, 16'h0000, 1'b0}, {2'h3, 8'h82, 8'h0D, 2'h0, 16'h0000, 1'b0},
    {2'h0, 8'h1A, 8'h0B, 2'h0, 16'h0000, 1'b0}, {2'h2, 8'h92, 8'h00, 2'h2, 16'h0000, 1'b1}};
  // gate type, gate present, destination access, exception
  localparam logic [19:0] GT [0:7] = '{{3'h4, 1'b1, 8'h9A, 8'h00}, {3'h5, 1'b1, 8'h81, 8'h00},
    {3'h6, 1'b1, 8'h9A, 8'h00}, {3'h7, 1'b1, 8'h9A, 8'h00}, {3'h4, 1'b1, 8'h81, 8'h0D},
    {3'h5, 1'b1, 8'h9A, 8'h0D}, {3'h6, 1'b1, 8'h92, 8'h0D}, {3'h7, 1'b0, 8'h9A, 8'h0B}};
  sdc_checker dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .mem_req(mem_req), .mem_we(mem_we), .mem_lock(mem_lock),
    .mem_addr(mem_addr), .mem_wdata(mem_wdata), .mem_rdata(mem_rdata), .mem_ack(mem_ack),
    .int_enable(int_enable));
  sdc_mem_model mem (.hclk(hclk), .mem_req(mem_req), .mem_we(mem_we), .mem_addr(mem_addr),
    .mem_wdata(mem_wdata), .slow(slow), .mem_rdata(mem_rdata), .mem_ack(mem_ack));
  initial begin
    hclk = 1'b0;
    forever #50 hclk = ~hclk;
  end
  always @(negedge hclk) begin
    if (mem_req && mem_ack) n_mem++;
    if (mem_req && !mem_lock) begin
      err_total++;
      $display("CHECK FAILED %0t memory request outside lock", $time);
    end
  end
  always @(posedge hclk) begin
    cyc++;
    if (cyc == 30000) begin
      err_total++;
      stop_test();
    end
  end
  task automatic stop_test();
    if (err_total == 0 && n_tests > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  task automatic wait_rdy(output logic [31:0] d);
    logic r;
    do begin
      @(negedge hclk);
      r = hreadyout;
      d = hrdata;
      @(posedge hclk);
    end while (r !== 1'b1);
  endtask
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] wd, output logic [31:0] d);
    @(posedge hclk);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= {24'h0, a};
    hwrite <= w;
    wait_rdy(d);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    wait_rdy(d);
  endtask
  task automatic run(input logic [2:0] cmd, input logic [1:0] seg, input logic [1:0] kind);
    int k;
    bus(1'b1, sdc_pkg::ADDR_CTRL, {22'h0, kind, 2'h0, seg, 1'b0, cmd}, rd);
    k = 0;
    do begin
      bus(1'b0, sdc_pkg::ADDR_STAT, 32'h0, rd);
      k++;
    end while (rd[1:0] !== 2'b10 && k < 200);
  endtask
  task automatic put(input logic [7:0] a, input logic [15:0] w0, input logic [15:0] w1, input logic [15:0] w2);
    mem.m[{1'b0, a[7:1]}] = w0;
    mem.m[{1'b0, a[7:1]} + 8'h1] = w1;
    mem.m[{1'b0, a[7:1]} + 8'h2] = w2;
    bus(1'b1, sdc_pkg::ADDR_DADDR, {24'h0, a}, rd);
  endtask
  initial begin
    {hresetn, hsel, hwrite, htrans, slow, haddr, hwdata} = '0;
    hsize = 3'h2;
    repeat (4) @(posedge hclk);
    hresetn <= 1'b1;
    for (int i = 0; i < 16; i++) begin
      slow <= 2'(i % 3);
      n0 = n_mem;
      put(8'h40, 16'h0100, 16'h5678, {LT[i][34:27], 8'h12});
      run(sdc_pkg::CMD_LOAD, LT[i][36:35], 2'h0);
      `CHK(rd[15:8], LT[i][26:19], "load exception")
      `CHK(rd[2], LT[i][26:19] != 8'h00, "load fault flag")
      if (LT[i][26:19] == 8'h00) begin
        `CHK(mem.m[8'h22][8], 1'b1, "accessed bit not written back")
        `CHK(n_mem - n0, 4, "load word count")
        n0 = n_mem;
        bus(1'b1, sdc_pkg::ADDR_OFFS, {16'h0, LT[i][16:1]}, rd);
        run(sdc_pkg::CMD_CHECK, LT[i][36:35], LT[i][18:17]);
        `CHK(rd[2], LT[i][0], "check fault flag")
        `CHK(rd[23:21], {LT[i][33:32], LT[i][30] & LT[i][29]}, "check privilege")
        `CHK(n_mem, n0, "memory touched by check")
      end
    end
    for (int i = 0; i < 4; i++) begin
      ty = (i == 3) ? 3'h1 : 3'(i + 1);
      put(8'h60, 16'hBEEF, 16'h3456, {i < 3, 2'b11, 2'b00, ty, 8'hAB});
      run(sdc_pkg::CMD_SYS, 2'h0, 2'h0);
      `CHK(rd[2], i == 3, "system present")
      if (i < 3) begin
        `CHK(rd[18:16], ty, "system type")
        `CHK(rd[23:22], (ty == 3'h2) ? 2'h0 : 2'h3, "system privilege")
        bus(1'b0, sdc_pkg::ADDR_SBASE, 32'h0, rd);
        `CHK(rd[23:0], 24'hAB3456, "system base")
        bus(1'b0, sdc_pkg::ADDR_SLIM, 32'h0, rd);
        `CHK(rd[15:0], 16'hBEEF, "system limit")
      end
    end
    for (int i = 0; i < 8; i++) begin
      ty = GT[i][19:17];
      ex = GT[i][7:0];
      bus(1'b1, sdc_pkg::ADDR_CTRL, 32'h0000_1000, rd);
      mem.m[8'h48] = 16'h0100;
      mem.m[8'h49] = 16'h0000;
      mem.m[8'h4A] = {GT[i][15:8], 8'h00};
      bus(1'b1, sdc_pkg::ADDR_GADDR, 32'h0000_0090, rd);
      put(8'h80, 16'h1234, 16'h0048, {GT[i][16], 2'b00, 2'b00, ty, 8'h05});
      run(sdc_pkg::CMD_GATE, 2'h0, 2'h0);
      `CHK(rd[15:8], ex, "gate exception")
      `CHK(int_enable, !(ty == 3'h6 && ex == 8'h00), "interrupt enable")
      if (ex == 8'h00) begin
        `CHK(rd[18:16], ty, "gate type")
        `CHK(rd[28:24], (ty == 3'h4) ? 5'h05 : 5'h00, "word count")
        bus(1'b0, sdc_pkg::ADDR_GATE, 32'h0, rd);
        `CHK(rd, {16'h0048, (ty == 3'h5) ? 16'h0000 : 16'h1234}, "gate destination")
      end
    end
    bus(1'b0, 8'h20, 32'h0, rd);
    `CHK(rd, 32'h0000_0000, "unmapped read")
    `CHK(hresp, 1'b0, "error response")
    stop_test();
  end
endmodule
`default_nettype wire
